// [src/psl_led_encoder.sv]
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
module psl_led_encoder
  import psl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire psl_pkg::psl_sense_s sense_i,
  input wire psl_pkg::psl_bus_s bus_i,
  output logic [7:0] rdata_o,
  output logic led_green_o,
  output logic led_yellow_o,
  output logic led_red_o,
  output logic [7:0] msg_o,
  output logic irq_o
);
  import psl_pkg::*;

  function automatic logic lvl_active(input logic contact, input logic nc);
    lvl_active = contact ^ nc;
  endfunction : lvl_active

  // ****************************************
  // Condition decode
  // ****************************************
  logic pre_lvl;
  logic dry_lvl;
  logic flow_bad;
  logic an_bad;
  logic [7:0] cfg_r;
  logic [7:0] cond;

  always_comb
  begin
    pre_lvl = lvl_active(sense_i.pre_contact, cfg_r[CFG_PRE_NC]);
    dry_lvl = lvl_active(sense_i.dry_contact, cfg_r[CFG_DRY_NC]);
    flow_bad = sense_i.no_flow | sense_i.low_flow;
    an_bad = cfg_r[CFG_ANALOG] &
             ((sense_i.analog_ua < AN_LO_UA) | (sense_i.analog_ua > AN_HI_UA));
    cond = '0;
    cond[MSG_SUPPLY] = sense_i.supply_bad;
    cond[MSG_FLOW_WARN] = flow_bad & ~cfg_r[CFG_FLOW_SHUT];
    // Dry run hides the pre-alarm only when two-stage monitoring is on
    cond[MSG_PRE_ALARM] = pre_lvl & ~(cfg_r[CFG_TWO_STAGE] & dry_lvl);
    cond[MSG_INTERNAL] = sense_i.internal_err;
    cond[MSG_FLOW_SHUT] = flow_bad & cfg_r[CFG_FLOW_SHUT];
    cond[MSG_RUPTURE] = sense_i.rupture;
    cond[MSG_DRY_RUN] = dry_lvl;
    cond[MSG_ANALOG] = an_bad;
  end

  // ****************************************
  // Flash timebase and stroke blink
  // ****************************************
  logic [31:0] flash_cnt_r;
  logic [31:0] flash_cnt_nxt;
  logic flash_ph_r;
  logic flash_ph_nxt;
  logic [31:0] blink_cnt_r;
  logic [31:0] blink_cnt_nxt;
  logic stroke_d_r;
  psl_grn_e grn_r;
  psl_grn_e grn_nxt;

  always_comb
  begin
    flash_cnt_nxt = flash_cnt_r + 32'h1;
    flash_ph_nxt = flash_ph_r;
    if (flash_cnt_r == 32'(FLASH_CYC - 1))
    begin
      flash_cnt_nxt = '0;
      flash_ph_nxt = ~flash_ph_r;
    end
    blink_cnt_nxt = (blink_cnt_r != '0) ? blink_cnt_r - 32'h1 : '0;
    grn_nxt = grn_r;
    unique case (grn_r)
      GRN_OFF:
        if (sense_i.on)
          grn_nxt = GRN_ON;
      GRN_ON:
        if (!sense_i.on)
          grn_nxt = GRN_OFF;
        else if (sense_i.stroke & ~stroke_d_r)
        begin
          grn_nxt = GRN_BLINK;
          blink_cnt_nxt = 32'(BLINK_CYC);
        end
      GRN_BLINK:
        if (!sense_i.on)
          grn_nxt = GRN_OFF;
        else if (blink_cnt_r == 32'h1)
          grn_nxt = GRN_ON;
      default:
        grn_nxt = GRN_OFF;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      flash_cnt_r <= '0;
      flash_ph_r <= 1'b0;
      blink_cnt_r <= '0;
      stroke_d_r <= 1'b0;
      grn_r <= GRN_OFF;
    end
    else
    begin
      flash_cnt_r <= flash_cnt_nxt;
      flash_ph_r <= flash_ph_nxt;
      blink_cnt_r <= blink_cnt_nxt;
      stroke_d_r <= sense_i.stroke;
      grn_r <= grn_nxt;
    end
  end

  // ****************************************
  // Lamps and messages
  // ****************************************
  logic yel_nxt;
  logic red_nxt;
  logic grn_lamp_nxt;

  always_comb
  begin
    // Steady sources win over flashing ones so a steady cause is never hidden
    yel_nxt = cond[MSG_SUPPLY] | cond[MSG_FLOW_WARN] |
              (cond[MSG_PRE_ALARM] & flash_ph_r);
    red_nxt = cond[MSG_INTERNAL] | cond[MSG_FLOW_SHUT] | cond[MSG_RUPTURE] |
              cond[MSG_ANALOG] | (cond[MSG_DRY_RUN] & flash_ph_r);
    grn_lamp_nxt = (grn_r == GRN_ON);
  end

  // ****************************************
  // Register file and interrupt
  // ****************************************
  logic [7:0] stat_r;
  logic [7:0] stat_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic [7:0] cfg_nxt;
  logic [7:0] rdata_nxt;
  logic [7:0] cond_d_r;

  always_comb
  begin
    cfg_nxt = cfg_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    if (bus_i.wr && bus_i.addr == REG_CFG)
      cfg_nxt = bus_i.wdata;
    if (bus_i.wr && bus_i.addr == REG_MASK)
      mask_nxt = bus_i.wdata;
    if (bus_i.wr && bus_i.addr == REG_STAT)
      stat_nxt = stat_r & ~bus_i.wdata;
    // Set after clear: a new condition in the clear cycle is kept
    stat_nxt = stat_nxt | (cond & ~cond_d_r);
    rdata_nxt = '0;
    if (bus_i.rd)
    begin
      unique case (bus_i.addr)
        REG_CFG: rdata_nxt = cfg_r;
        REG_STAT: rdata_nxt = stat_r;
        REG_MASK: rdata_nxt = mask_r;
        REG_MSG: rdata_nxt = msg_o;
        REG_LAMP: rdata_nxt = {5'h00, led_red_o, led_yellow_o, led_green_o};
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      cfg_r <= CFG_RST;
      mask_r <= MASK_RST;
      stat_r <= '0;
      cond_d_r <= '0;
      rdata_o <= '0;
      led_green_o <= 1'b0;
      led_yellow_o <= 1'b0;
      led_red_o <= 1'b0;
      msg_o <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      cond_d_r <= cond;
      rdata_o <= rdata_nxt;
      led_green_o <= grn_lamp_nxt;
      led_yellow_o <= yel_nxt;
      led_red_o <= red_nxt;
      msg_o <= cond;
      irq_o <= |(stat_nxt & mask_nxt);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_supply_yellow: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    sense_i.supply_bad |=> led_yellow_o)
    else $error("supply fault did not light yellow");
  chk_flow_warn: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (sense_i.no_flow && !cfg_r[CFG_FLOW_SHUT]) |=> led_yellow_o)
    else $error("flow warning did not light yellow");
  chk_flow_shut: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (sense_i.low_flow && cfg_r[CFG_FLOW_SHUT]) |=> led_red_o)
    else $error("flow shut-off did not light red");
  chk_rupture_red: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    sense_i.rupture |=> led_red_o && msg_o[MSG_RUPTURE])
    else $error("rupture did not light red");
  chk_internal_red: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    sense_i.internal_err |=> led_red_o && msg_o[MSG_INTERNAL])
    else $error("internal error not shown");
  chk_analog_low: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (cfg_r[CFG_ANALOG] && sense_i.analog_ua < AN_LO_UA) |=> led_red_o)
    else $error("low analog current not shown");
  chk_pre_suppress: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (cfg_r[CFG_TWO_STAGE] && dry_lvl) |=> !msg_o[MSG_PRE_ALARM])
    else $error("pre-alarm shown during dry run");
  chk_pre_default: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (!cfg_r[CFG_PRE_NC] && !(cfg_r[CFG_TWO_STAGE] && dry_lvl) && sense_i.pre_contact)
    |=> msg_o[MSG_PRE_ALARM])
    else $error("closed pre-alarm contact not seen");
  chk_green_ready: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (grn_r == GRN_OFF && sense_i.on) ##1 (sense_i.on && !sense_i.stroke) |=> led_green_o)
    else $error("green not on when ready");
  chk_stroke_blink: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (grn_r == GRN_ON && sense_i.on && sense_i.stroke && !stroke_d_r) ##1 sense_i.on
    |=> !led_green_o)
    else $error("stroke gave no blink");
  chk_dry_flash: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (dry_lvl && !sense_i.internal_err && !sense_i.rupture && !flow_bad && !an_bad
     && !flash_ph_r) |=> !led_red_o)
    else $error("dry run red not flashing");

endmodule : psl_led_encoder

// [src/psl_pkg.sv]
package psl_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 200_000_000;
  localparam int BLINK_MS = 100;
  localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  localparam int FLASH_MS = 250;
  localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;

  // ****************************************
  // Analog window in microamperes
  // ****************************************
  localparam logic [15:0] AN_LO_UA = 16'h0DAC;
  localparam logic [15:0] AN_HI_UA = 16'h5014;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_MASK = 4'h2;
  localparam logic [3:0] REG_MSG = 4'h3;
  localparam logic [3:0] REG_LAMP = 4'h4;

  // Config fields
  localparam int CFG_PRE_NC = 0;
  localparam int CFG_DRY_NC = 1;
  localparam int CFG_TWO_STAGE = 2;
  localparam int CFG_FLOW_SHUT = 3;
  localparam int CFG_ANALOG = 4;
  localparam logic [7:0] CFG_RST = 8'h04;

  // Message and status bit positions
  localparam int MSG_SUPPLY = 0;
  localparam int MSG_FLOW_WARN = 1;
  localparam int MSG_PRE_ALARM = 2;
  localparam int MSG_INTERNAL = 3;
  localparam int MSG_FLOW_SHUT = 4;
  localparam int MSG_RUPTURE = 5;
  localparam int MSG_DRY_RUN = 6;
  localparam int MSG_ANALOG = 7;
  localparam logic [7:0] MASK_RST = 8'h00;

  typedef struct packed {
    logic on;
    logic stroke;
    logic supply_bad;
    logic no_flow;
    logic low_flow;
    logic rupture;
    logic internal_err;
    logic pre_contact;
    logic dry_contact;
    logic [15:0] analog_ua;
  } psl_sense_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } psl_bus_s;

  typedef enum logic [2:0] {
    GRN_OFF = 3'b001,
    GRN_ON = 3'b010,
    GRN_BLINK = 3'b100
  } psl_grn_e;

endpackage : psl_pkg

// [tb/psl_pump_model.sv]
`timescale 1ns/1ps
// ****************************************
// Pump core sensor side
// ****************************************
module psl_pump_model
  import psl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [8:0] lvl_i,
  input wire logic [15:0] ua_i,
  input wire logic stroke_en_i,
  output psl_pkg::psl_sense_s sense_o
);
  // Initialised at declaration so the counter keeps a single procedural driver
  logic [5:0] cnt_r = 6'h00;
  // Two-cycle stroke pulse every 64 cycles, so the encoder sees a clean rising edge
  always_ff @(posedge mclk_i)
  begin
    cnt_r <= cnt_r + 6'h01;
    sense_o <= {lvl_i, ua_i};
    if (stroke_en_i && (cnt_r < 6'h02))
    begin
      sense_o.stroke <= 1'b1;
    end
  end
endmodule : psl_pump_model

// [tb/tb_pump_status_led_encoder.sv]
`timescale 1ns/1ps
module tb_pump_status_led_encoder;
  import psl_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [8:0] lvl = 9'h000;
  logic [15:0] ua = 16'h2710;
  logic stroke_en = 1'b0;
  psl_sense_s sense;
  psl_bus_s bus = '0;
  logic [7:0] rdata_o, msg_o, rd_v;
  logic led_green_o, led_yellow_o, led_red_o, irq_o;
  int err_count = 0;
  int samples_checked = 0;

  psl_pump_model u_psl_pump_model (.mclk_i(mclk_i), .lvl_i(lvl), .ua_i(ua),
    .stroke_en_i(stroke_en), .sense_o(sense));
  psl_led_encoder u_psl_led_encoder (.mclk_i(mclk_i), .rstn_i(rstn_i), .sense_i(sense),
    .bus_i(bus), .rdata_o(rdata_o), .led_green_o(led_green_o), .led_yellow_o(led_yellow_o),
    .led_red_o(led_red_o), .msg_o(msg_o), .irq_o(irq_o));

  initial
  begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : wait_n

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    bus.wr <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    bus.rd <= 1'b0;
    #1;
    d = rdata_o;
  endtask : reg_rd

  // One sensor condition: flashing lamps are left out through the mask
  task automatic steady(input logic [7:0] cfg, input logic [8:0] l, input logic [15:0] u,
                        input logic [2:0] m, input logic [2:0] el, input logic [7:0] em);
    reg_wr(REG_CFG, cfg);
    @(posedge mclk_i);
    lvl <= l;
    ua <= u;
    wait_n(4);
    chk({5'h00, m & {led_red_o, led_yellow_o, led_green_o}}, {5'h00, el});
    chk(msg_o, em);
    reg_rd(REG_LAMP, rd_v);
    chk({5'h00, rd_v[2:0] & m}, {5'h00, el});
    @(posedge mclk_i);
    lvl <= 9'h000;
    ua <= 16'h2710;
    wait_n(4);
  endtask : steady

  task automatic give_verdict;
    $display("Mismatches %0d, comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (8) @(posedge mclk_i);
    rstn_i <= 1'b1;
    reg_rd(REG_CFG, rd_v);
    chk(rd_v, CFG_RST);
    reg_rd(REG_MASK, rd_v);
    chk(rd_v, MASK_RST);
    reg_rd(4'hF, rd_v);
    chk(rd_v, 8'h00);
    steady(8'h04, 9'h040, 16'h2710, 3'h7, 3'h2, 8'h01);
    steady(8'h04, 9'h020, 16'h2710, 3'h7, 3'h2, 8'h02);
    steady(8'h0C, 9'h010, 16'h2710, 3'h7, 3'h4, 8'h10);
    steady(8'h04, 9'h008, 16'h2710, 3'h7, 3'h4, 8'h20);
    steady(8'h04, 9'h004, 16'h2710, 3'h7, 3'h4, 8'h08);
    steady(8'h14, 9'h000, 16'h0DAB, 3'h7, 3'h4, 8'h80);
    steady(8'h14, 9'h000, 16'h0DAC, 3'h7, 3'h0, 8'h00);
    steady(8'h14, 9'h000, 16'h5015, 3'h7, 3'h4, 8'h80);
    steady(8'h14, 9'h000, 16'h5014, 3'h7, 3'h0, 8'h00);
    steady(8'h04, 9'h002, 16'h2710, 3'h5, 3'h0, 8'h04);
    steady(8'h05, 9'h000, 16'h2710, 3'h5, 3'h0, 8'h04);
    steady(8'h07, 9'h003, 16'h2710, 3'h7, 3'h0, 8'h00);
    steady(8'h04, 9'h003, 16'h2710, 3'h3, 3'h0, 8'h40);
    steady(8'h04, 9'h100, 16'h2710, 3'h7, 3'h1, 8'h00);
    reg_rd(REG_STAT, rd_v);
    chk(rd_v, 8'hFF);
    chk({7'h00, irq_o}, 8'h00);
    reg_wr(REG_MASK, 8'h01);
    wait_n(1);
    chk({7'h00, irq_o}, 8'h01);
    reg_wr(REG_STAT, 8'h01);
    wait_n(1);
    chk({7'h00, irq_o}, 8'h00);
    reg_rd(REG_STAT, rd_v);
    chk(rd_v, 8'hFE);
    @(posedge mclk_i);
    lvl <= 9'h140;
    wait_n(4);
    chk({7'h00, irq_o}, 8'h01);
    chk({7'h00, led_green_o}, 8'h01);
    stroke_en <= 1'b1;
    wait_n(80);
    chk({7'h00, led_green_o}, 8'h00);
    give_verdict();
  end

  initial
  begin
    wait_n(20000);
    err_count++;
    give_verdict();
  end
endmodule : tb_pump_status_led_encoder
